/* hdl/hbb_burst_if.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hbb_regs.svh"

// -----------------------------------------------------------------------------
// Word FIFO with registered flags
// -----------------------------------------------------------------------------
module hbb_fifo #(
  parameter int W = 32,
  parameter int D = 24
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   clk_en_i,
  // Fill side
  input  wire logic                   in_valid_i,
  input  wire logic [W-1:0]           in_data_i,
  output logic                        in_ready_o,
  // Drain side
  output logic                        out_valid_o,
  input  wire logic                   out_ready_i,
  output logic [W-1:0]                out_data_o,
  output logic [$clog2(D+1)-1:0]      count_o
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D+1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wptr;
    logic [AW-1:0]       rptr;
    logic [CW-1:0]       cnt;
    logic                in_rdy;
  } hbb_fifo_st_t;

  hbb_fifo_st_t s_reg;
  hbb_fifo_st_t s_next;
  logic         push;
  logic         pop;

  // Handshakes on both sides
  assign push = in_valid_i && s_reg.in_rdy;
  assign pop  = out_ready_i && (s_reg.cnt != '0);

  // Pointer, storage and flag update
  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wptr] = in_data_i;
      s_next.wptr = (s_reg.wptr == AW'(D-1)) ? '0 : AW'(s_reg.wptr + 1'b1);
    end
    if (pop) begin
      s_next.rptr = (s_reg.rptr == AW'(D-1)) ? '0 : AW'(s_reg.rptr + 1'b1);
    end
    s_next.cnt    = CW'(s_reg.cnt + CW'(push) - CW'(pop));
    s_next.in_rdy = (s_next.cnt < CW'(D));
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_reg <= '{mem: '0, wptr: '0, rptr: '0, cnt: '0, in_rdy: 1'b1};
    end else if (clk_en_i) begin
      s_reg <= s_next;
    end
  end

  assign in_ready_o  = s_reg.in_rdy;
  assign out_valid_o = (s_reg.cnt != '0);
  assign out_data_o  = s_reg.mem[s_reg.rptr];
  assign count_o     = s_reg.cnt;
endmodule

// -----------------------------------------------------------------------------
// Host burst bus interface
// -----------------------------------------------------------------------------
module hbb_burst_if (
  // Clock, reset, enable
  input  wire logic                    clk_i,
  input  wire logic                    reset_n_i,
  input  wire logic                    clk_en_i,
  // Bus mode pins
  input  wire logic                    bus_style_i,
  input  wire logic                    big_endian_i,
  input  wire logic                    proc_variant_i,
  // Host bus arbitration and master outputs
  input  wire logic                    bus_grant_i,
  output hbb_pkg::hbb_bus_t            bus_o,
  // DMA data fill and start address
  input  wire logic                    wr_valid_i,
  input  wire logic [`HBB_WORD_W-1:0]  wr_data_i,
  output logic                         wr_ready_o,
  input  wire logic                    addr_ld_i,
  input  wire logic [`HBB_WORD_W-1:0]  addr_ld_data_i,
  // Instruction pointer and fetch control
  input  wire logic                    auto_start_n_i,
  input  wire hbb_pkg::hbb_ip_wr_t     ip_wr_i,
  input  wire logic                    fetch_adv_i,
  input  wire logic                    irq_cond_i,
  output logic [`HBB_WORD_W-1:0]       ip_o,
  output logic                         fetch_run_o,
  // General purpose pins
  input  wire logic [3:0]              gp_in_i,
  output logic [3:0]                   gp_in_o,
  input  wire logic                    gp_wr_i,
  input  wire logic                    gp_wdata_i,
  output logic                         gp_out_o,
  // Connectivity test
  input  wire logic                    test_in_i,
  output logic                         test_out_o
);
  import hbb_pkg::*;

  typedef struct packed {
    logic [`HBB_SYNC_W-1:0]  sync1;
    logic [`HBB_SYNC_W-1:0]  sync2;
    hbb_bus_st_t             st;
    logic [1:0]              beat;
    logic [2:0]              bursts;
    logic [2:0]              quota;
    logic [`HBB_WORD_W-1:0]  addr;
    hbb_bus_t                bus;
    hbb_ip_st_t              ip_st;
    logic [1:0]              boot_cnt;
    logic [`HBB_WORD_W-1:0]  ip;
    logic                    run;
    logic [3:0]              gp_in;
    logic                    gp_out;
    logic                    test_out;
  } hbb_top_st_t;

  hbb_top_st_t             s_reg;
  hbb_top_st_t             s_next;
  logic                    fifo_pop;
  logic                    fifo_valid;
  logic [`HBB_WORD_W-1:0]  fifo_data;
  logic [`HBB_CNT_W-1:0]   fifo_cnt;
  logic [`HBB_CNT_W-1:0]   rem;
  logic                    be_mode;
  logic                    cont;

  // ---------------------------------------------------------------------------
  // DMA FIFO
  // ---------------------------------------------------------------------------
  hbb_fifo #(
    .W (`HBB_WORD_W),
    .D (`HBB_FIFO_WORDS)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .clk_en_i    (clk_en_i),
    .in_valid_i  (wr_valid_i),
    .in_data_i   (wr_data_i),
    .in_ready_o  (wr_ready_o),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_data),
    .count_o     (fifo_cnt)
  );

  // ---------------------------------------------------------------------------
  // Mode decode and continuation decision
  // ---------------------------------------------------------------------------
  assign be_mode  = s_reg.sync2[`HBB_S_STYLE] && s_reg.sync2[`HBB_S_VARIANT];
  assign fifo_pop = (s_reg.st == HBB_B_BEAT) && fifo_valid;
  assign rem      = `HBB_CNT_W'(fifo_cnt - 1'b1);
  // Continue on eight left, or fill the quota set at grant
  assign cont     = (rem >= `HBB_CONT_THRESH) ||
                    ((3'(s_reg.bursts + 1'b1) < s_reg.quota) && (rem >= `HBB_BURST_BEATS));

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    // Two-flop pin synchronisers
    s_next.sync1 = {bus_style_i, big_endian_i, proc_variant_i, bus_grant_i,
                    auto_start_n_i, gp_in_i, test_in_i};
    s_next.sync2 = s_reg.sync1;
    s_next.bus.burst_start = 1'b0;
    s_next.bus.beat_valid  = 1'b0;

    // Start address load, forced to a line boundary
    if (addr_ld_i && (s_reg.st == HBB_B_IDLE)) begin
      s_next.addr = addr_ld_data_i & `HBB_ALIGN_MASK;
    end

    // Burst sequencing
    unique case (s_reg.st)
      HBB_B_IDLE: begin
        if (fifo_cnt >= `HBB_BURST_BEATS) begin
          s_next.bus.bus_req = 1'b1;
          s_next.st          = HBB_B_REQ;
        end
      end
      HBB_B_REQ: begin
        if (s_reg.sync2[`HBB_S_GRANT]) begin
          s_next.st     = HBB_B_BEAT;
          s_next.beat   = 2'h0;
          s_next.bursts = 3'h0;
          s_next.quota  = (fifo_cnt >= `HBB_FULL_LOAD) ? `HBB_MAX_BURSTS : 3'h1;
        end
      end
      HBB_B_BEAT: begin
        // One long word per clock, no per-word handshake
        s_next.bus.beat_valid  = 1'b1;
        s_next.bus.burst_start = (s_reg.beat == 2'h0);
        s_next.bus.addr        = s_reg.addr;
        s_next.bus.data        = s_reg.sync2[`HBB_S_BIGEND] ? fifo_data :
                                 {fifo_data[7:0], fifo_data[15:8], fifo_data[23:16], fifo_data[31:24]};
        s_next.addr            = s_reg.addr + `HBB_BEAT_STEP;
        s_next.beat            = 2'(s_reg.beat + 1'b1);
        if (s_reg.beat == `HBB_LAST_BEAT) begin
          s_next.bursts = 3'(s_reg.bursts + 1'b1);
          s_next.st     = cont ? HBB_B_BEAT : HBB_B_REL;
        end
      end
      HBB_B_REL: begin
        s_next.bus.bus_req = 1'b0;
        s_next.st          = HBB_B_IDLE;
      end
    endcase

    // Pin functions by mode
    s_next.bus.rw        = be_mode ? ~`HBB_RW_WRITE : `HBB_RW_WRITE;
    s_next.bus.xfer_size = be_mode ? `HBB_BE_ALL_ON : `HBB_SIZE_LONG;
    s_next.bus.low_addr  = be_mode ? `HBB_BE_ALL_ON : s_next.addr[1:0];
    s_next.bus.far_mem   = s_next.addr[`HBB_FAR_BIT];

    // Instruction pointer start-up and run control
    unique case (s_reg.ip_st)
      HBB_I_BOOT: begin
        s_next.boot_cnt = 2'(s_reg.boot_cnt + 1'b1);
        if (s_reg.boot_cnt == `HBB_BOOT_SETTLE) begin
          if (!s_reg.sync2[`HBB_S_AUTO_N]) begin
            s_next.ip    = `HBB_IP_RESET;
            s_next.run   = 1'b1;
            s_next.ip_st = HBB_I_RUN;
          end else begin
            s_next.ip_st = HBB_I_WAIT;
          end
        end
      end
      HBB_I_WAIT, HBB_I_HALT: begin
        if (ip_wr_i.wr) begin
          s_next.ip    = ip_wr_i.data;
          s_next.run   = 1'b1;
          s_next.ip_st = HBB_I_RUN;
        end
      end
      HBB_I_RUN: begin
        if (irq_cond_i) begin
          s_next.run   = 1'b0;
          s_next.ip_st = HBB_I_HALT;
        end else if (ip_wr_i.wr) begin
          s_next.ip = ip_wr_i.data;
        end else if (fetch_adv_i) begin
          s_next.ip = s_reg.ip + `HBB_BEAT_STEP;
        end
      end
    endcase

    // General purpose pins and AND tree
    s_next.gp_in    = s_reg.sync2[`HBB_S_GP_HI:`HBB_S_GP_LO];
    s_next.gp_out   = gp_wr_i ? gp_wdata_i : s_reg.gp_out;
    s_next.test_out = &s_reg.sync2;
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_reg <= '{sync1: '0, sync2: '0, st: HBB_B_IDLE, beat: '0, bursts: '0, quota: '0,
                 addr: '0, bus: '0, ip_st: HBB_I_BOOT, boot_cnt: '0, ip: `HBB_IP_RESET,
                 run: 1'b0, gp_in: '0, gp_out: 1'b0, test_out: 1'b0};
    end else if (clk_en_i) begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign bus_o       = s_reg.bus;
  assign ip_o        = s_reg.ip;
  assign fetch_run_o = s_reg.run;
  assign gp_in_o     = s_reg.gp_in;
  assign gp_out_o    = s_reg.gp_out;
  assign test_out_o  = s_reg.test_out;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i || !clk_en_i);

  AST_BURST_FOUR: assert property (
    $rose(bus_o.burst_start) |-> bus_o.beat_valid [*4] ##1 (!bus_o.beat_valid || bus_o.burst_start))
    else $error("burst length is not four long words");

  AST_ONE_ARB: assert property (
    (bus_o.beat_valid && !$past(bus_o.beat_valid)) |-> $past(s_reg.sync2[`HBB_S_GRANT]))
    else $error("burst began without a grant");

  AST_HOLD_BUS: assert property (
    bus_o.beat_valid |-> bus_o.bus_req)
    else $error("bus request dropped during a burst");

  AST_CONTINUE: assert property (
    (s_reg.st == HBB_B_BEAT && s_reg.beat == `HBB_LAST_BEAT && rem >= `HBB_CONT_THRESH)
      |=> s_reg.st == HBB_B_BEAT)
    else $error("burst did not continue with eight words left");

  AST_ALIGN: assert property (
    bus_o.burst_start |-> bus_o.addr[3:0] == 4'h0 ##1 bus_o.addr == $past(bus_o.addr) + `HBB_BEAT_STEP)
    else $error("burst not aligned or step not four");

  AST_DIR: assert property (
    bus_o.beat_valid |-> bus_o.rw == (be_mode ? ~`HBB_RW_WRITE : `HBB_RW_WRITE))
    else $error("direction pin polarity wrong for mode");

  AST_ENABLES: assert property (
    (bus_o.beat_valid && be_mode && $stable(be_mode)) |-> bus_o.low_addr == `HBB_BE_ALL_ON)
    else $error("low address pins not acting as enables");

  AST_AUTOSTART: assert property (
    (s_reg.ip_st == HBB_I_BOOT && s_reg.boot_cnt == `HBB_BOOT_SETTLE && !s_reg.sync2[`HBB_S_AUTO_N])
      |=> fetch_run_o && ip_o == `HBB_IP_RESET)
    else $error("auto-start did not begin at address zero");

  AST_HALT: assert property (
    (fetch_run_o && irq_cond_i) |=> !fetch_run_o)
    else $error("fetching went on after an interrupt condition");

  AST_FAR: assert property (
    bus_o.beat_valid |=> (!bus_o.beat_valid || bus_o.addr[`HBB_FAR_BIT] == $past(bus_o.far_mem)))
    else $error("near or far indicator does not match the next access");
endmodule

`default_nettype wire

/* include/hbb_pkg.sv */
`default_nettype none
`include "hbb_regs.svh"

package hbb_pkg;

  // Bus master sequencing
  typedef enum logic [1:0] {HBB_B_IDLE, HBB_B_REQ, HBB_B_BEAT, HBB_B_REL} hbb_bus_st_t;

  // Instruction pointer sequencing
  typedef enum logic [1:0] {HBB_I_BOOT, HBB_I_WAIT, HBB_I_RUN, HBB_I_HALT} hbb_ip_st_t;

  // Host bus master outputs
  typedef struct packed {
    logic                    bus_req;
    logic                    beat_valid;
    logic                    burst_start;
    logic                    rw;
    logic [1:0]              xfer_size;
    logic [1:0]              low_addr;
    logic [`HBB_WORD_W-1:0]  addr;
    logic [`HBB_WORD_W-1:0]  data;
    logic                    far_mem;
  } hbb_bus_t;

  // Host write to the instruction pointer
  typedef struct packed {
    logic                    wr;
    logic [`HBB_WORD_W-1:0]  data;
  } hbb_ip_wr_t;

endpackage

`default_nettype wire

/* include/hbb_regs.svh */
`ifndef HBB_REGS_SVH
`define HBB_REGS_SVH

// -----------------------------------------------------------------------------
// Clock and timing
// -----------------------------------------------------------------------------
`define HBB_CLK_HZ        40000000
`define HBB_BOOT_SETTLE   2'h3

// -----------------------------------------------------------------------------
// DMA FIFO and burst shape
// -----------------------------------------------------------------------------
`define HBB_FIFO_BYTES    96
`define HBB_FIFO_WORDS    (`HBB_FIFO_BYTES / 4)
`define HBB_WORD_W        32
`define HBB_CNT_W         5
`define HBB_BURST_BEATS   5'h04
`define HBB_CONT_THRESH   5'h08
`define HBB_FULL_LOAD     5'h10
`define HBB_LAST_BEAT     2'h3
`define HBB_MAX_BURSTS    3'h4
`define HBB_BEAT_STEP     32'h0000_0004
`define HBB_ALIGN_MASK    32'hffff_fff0

// -----------------------------------------------------------------------------
// Pin codes and reset values
// -----------------------------------------------------------------------------
`define HBB_IP_RESET      32'h0000_0000
`define HBB_RW_WRITE      1'h0
`define HBB_SIZE_LONG     2'h0
`define HBB_BE_ALL_ON     2'h0
`define HBB_FAR_BIT       31

// -----------------------------------------------------------------------------
// Synchroniser vector layout
// -----------------------------------------------------------------------------
`define HBB_SYNC_W        10
`define HBB_S_STYLE       9
`define HBB_S_BIGEND      8
`define HBB_S_VARIANT     7
`define HBB_S_GRANT       6
`define HBB_S_AUTO_N      5
`define HBB_S_GP_HI       4
`define HBB_S_GP_LO       1
`define HBB_S_TEST        0

`endif

/* tb/hbb_burst_if_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module hbb_burst_if_tb;
  import hbb_pkg::*;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic        clk_i          = 1'b0;
  logic        reset_n_i      = 1'b0;
  logic        bus_style_i    = 1'b0;
  logic        big_endian_i   = 1'b1;
  logic        proc_variant_i = 1'b0;
  logic        wr_valid_i     = 1'b0;
  logic [31:0] wr_data_i      = 32'h0;
  logic        addr_ld_i      = 1'b0;
  logic [31:0] addr_ld_data_i = 32'h0;
  logic        auto_start_n_i = 1'b0;
  hbb_ip_wr_t  ip_wr_i        = '0;
  logic        fetch_adv_i    = 1'b0;
  logic        irq_cond_i     = 1'b0;
  logic [3:0]  gp_in_i        = 4'h0;
  logic        gp_wr_i        = 1'b0;
  logic        gp_wdata_i     = 1'b0;
  logic        test_in_i      = 1'b0;
  logic        clk_en_i       = 1'b1;
  logic [1:0]  grant_mode     = 2'h1;
  logic        bus_grant_i;
  hbb_bus_t    bus_o;
  logic        wr_ready_o;
  logic [31:0] ip_o;
  logic        fetch_run_o;
  logic [3:0]  gp_in_o;
  logic        gp_out_o;
  logic        test_out_o;
  int          mismatches     = 0;
  int          checked        = 0;
  int          cycles         = 0;

  always #12.5 clk_i = ~clk_i;

  hbb_burst_if DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .bus_style_i(bus_style_i),
    .big_endian_i(big_endian_i), .proc_variant_i(proc_variant_i), .bus_grant_i(bus_grant_i), .bus_o(bus_o),
    .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i), .wr_ready_o(wr_ready_o), .addr_ld_i(addr_ld_i),
    .addr_ld_data_i(addr_ld_data_i), .auto_start_n_i(auto_start_n_i), .ip_wr_i(ip_wr_i),
    .fetch_adv_i(fetch_adv_i), .irq_cond_i(irq_cond_i), .ip_o(ip_o), .fetch_run_o(fetch_run_o),
    .gp_in_i(gp_in_i), .gp_in_o(gp_in_o), .gp_wr_i(gp_wr_i), .gp_wdata_i(gp_wdata_i), .gp_out_o(gp_out_o),
    .test_in_i(test_in_i), .test_out_o(test_out_o));

  hbb_host_model host (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_i(bus_o), .grant_mode_i(grant_mode),
    .bus_grant_o(bus_grant_i));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Start address is only taken while the engine is idle
  task automatic load_addr(input logic [31:0] a);
    @(posedge clk_i);
    addr_ld_i      <= 1'b1;
    addr_ld_data_i <= a;
    @(posedge clk_i);
    addr_ld_i      <= 1'b0;
    addr_ld_data_i <= ~a;
  endtask

  // Offer n words, each held until the edge where ready was seen high
  task automatic fill(input int n, input int tries, input logic [31:0] b, output int got);
    logic rdy;
    got = 0;
    @(posedge clk_i);
    wr_valid_i <= 1'b1;
    wr_data_i  <= b;
    while (got < n && tries > 0) begin
      @(negedge clk_i);
      rdy = wr_ready_o;
      @(posedge clk_i);
      tries--;
      if (rdy === 1'b1) begin
        got++;
        wr_data_i <= (got < n && tries > 0) ? b + got : ~(b + got - 1);
      end
    end
    wr_valid_i <= 1'b0;
  endtask

  task automatic wait_beats(input int n);
    int t;
    t = 0;
    while (host.addr_q.size() < n && t < 2000) begin
      @(posedge clk_i);
      t++;
    end
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    check("beat count", host.addr_q.size(), n);
    check("bus released", bus_o.bus_req, 32'h0);
  endtask

  task automatic clear_host();
    host.addr_q.delete();
    host.data_q.delete();
    host.ctl_q.delete();
    host.bursts  = 0;
    host.tenures = 0;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic test_boot();
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    check("pointer after boot", ip_o, 32'h0);
    check("fetch running", fetch_run_o, 32'h1);
    @(posedge clk_i) fetch_adv_i <= 1'b1;
    @(posedge clk_i) fetch_adv_i <= 1'b0;
    @(negedge clk_i);
    check("pointer step", ip_o, 32'h4);
    @(posedge clk_i) irq_cond_i <= 1'b1;
    @(posedge clk_i) irq_cond_i <= 1'b0;
    @(negedge clk_i);
    check("fetch after interrupt", fetch_run_o, 32'h0);
    @(posedge clk_i) ip_wr_i <= {1'b1, 32'h0000_0200};
    @(posedge clk_i) ip_wr_i <= {1'b0, 32'hffff_fdff};
    @(negedge clk_i);
    check("pointer written", ip_o, 32'h0000_0200);
    $display("test boot done");
  endtask

  // One burst in each bus style and variant combination, endianness following variant
  task automatic test_modes();
    logic [31:0] w;
    int          got;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_i);
      bus_style_i    <= m[1];
      proc_variant_i <= m[0];
      big_endian_i   <= m[0];
      repeat (4) @(posedge clk_i);
      load_addr(32'h0000_1234 + m * 32'h40);
      fill(4, 8, 32'h1122_3340 + m, got);
      wait_beats(4);
      check("bursts", host.bursts, 32'h1);
      for (int i = 0; i < 4; i++) begin
        w = 32'h1122_3340 + m + i;
        if (m[0] == 1'b0) w = {<<8{w}};
        check("address", host.addr_q[i], 32'h0000_1230 + m * 32'h40 + i * 4);
        check("data", host.data_q[i], w);
        check("direction", host.ctl_q[i][5], (m == 3));
        check("size and low address", host.ctl_q[i][4:1], 32'h0);
      end
      clear_host();
    end
    $display("test modes done");
  endtask

  task automatic test_tenure();
    int got;
    @(posedge clk_i) grant_mode <= 2'h0;
    load_addr(32'h8000_0100);
    fill(16, 20, 32'h0000_5000, got);
    @(posedge clk_i) grant_mode <= 2'h1;
    wait_beats(16);
    check("tenures", host.tenures, 32'h1);
    check("bursts", host.bursts, 32'h4);
    for (int i = 0; i < 16; i++) begin
      check("address", host.addr_q[i], 32'h8000_0100 + i * 4);
      check("data", host.data_q[i], 32'h0000_5000 + i);
      check("far memory", host.ctl_q[i][0], 32'h1);
    end
    clear_host();
    $display("test tenure done");
  endtask

  // Fill until refused with grant held off, then drain
  task automatic test_full();
    int got;
    @(posedge clk_i) grant_mode <= 2'h0;
    load_addr(32'h0000_2000);
    fill(30, 40, 32'h0000_7000, got);
    check("words taken", got, 32'd24);
    @(negedge clk_i);
    check("ready when full", wr_ready_o, 32'h0);
    @(posedge clk_i) grant_mode <= 2'h1;
    wait_beats(24);
    check("bursts", host.bursts, 32'h6);
    check("last data", host.data_q[23], 32'h0000_7017);
    check("near memory", host.ctl_q[0][0], 32'h0);
    clear_host();
    $display("test full done");
  endtask

  task automatic test_pins();
    @(posedge clk_i);
    grant_mode     <= 2'h2;
    bus_style_i    <= 1'b1;
    big_endian_i   <= 1'b1;
    proc_variant_i <= 1'b1;
    auto_start_n_i <= 1'b1;
    gp_in_i        <= 4'hf;
    test_in_i      <= 1'b1;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    check("and tree high", test_out_o, 32'h1);
    check("gp inputs", gp_in_o, 32'hf);
    @(posedge clk_i) gp_in_i <= 4'h6;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    check("and tree low", test_out_o, 32'h0);
    check("gp inputs", gp_in_o, 32'h6);
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk_i);
      gp_wr_i    <= 1'b1;
      gp_wdata_i <= v[0];
      @(posedge clk_i) gp_wr_i <= 1'b0;
      @(negedge clk_i);
      check("gp output", gp_out_o, v);
    end
    // Clock enable low freezes all state, so this pin write is lost
    @(posedge clk_i);
    clk_en_i   <= 1'b0;
    gp_wr_i    <= 1'b1;
    gp_wdata_i <= 1'b1;
    @(posedge clk_i);
    clk_en_i   <= 1'b1;
    gp_wr_i    <= 1'b0;
    @(negedge clk_i);
    check("gp output frozen", gp_out_o, 32'h0);
    $display("test pins done");
  endtask

  // Mid-run reset with the sense pin high: fetching waits for the host
  task automatic test_wait();
    @(posedge clk_i) reset_n_i <= 1'b0;
    @(negedge clk_i);
    check("ready in reset", wr_ready_o, 32'h1);
    check("request in reset", bus_o.bus_req, 32'h0);
    @(posedge clk_i) reset_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    check("fetch held", fetch_run_o, 32'h0);
    check("pointer held", ip_o, 32'h0);
    @(posedge clk_i) ip_wr_i <= {1'b1, 32'h0000_0400};
    @(posedge clk_i) ip_wr_i <= {1'b0, 32'hffff_fbff};
    @(negedge clk_i);
    check("pointer from host", ip_o, 32'h0000_0400);
    check("fetch started", fetch_run_o, 32'h1);
    $display("test wait done");
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and hang guard
  // ---------------------------------------------------------------------------
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    test_boot();
    test_modes();
    test_tenure();
    test_full();
    test_pins();
    test_wait();
    give_verdict();
  end
endmodule
`default_nettype wire

/* tb/hbb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------------------
// Host bus arbiter and system memory
// -----------------------------------------------------------------------------
module hbb_host_model (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  // Bus master side of the block
  input  wire hbb_pkg::hbb_bus_t bus_i,
  input  wire logic [1:0]        grant_mode_i,
  output logic                   bus_grant_o
);
  import hbb_pkg::*;
  logic [31:0] addr_q[$];
  logic [31:0] data_q[$];
  logic [5:0]  ctl_q[$];
  int          bursts;
  int          tenures;
  logic        req_reg;

  // Grant: 0 withheld, 1 follows request, 2 held high
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus_grant_o <= 1'b0;
      req_reg     <= 1'b0;
    end else begin
      bus_grant_o <= (grant_mode_i == 2'h2) || (grant_mode_i == 2'h1 && bus_i.bus_req);
      req_reg     <= bus_i.bus_req;
    end
  end

  // Memory takes one long word each clock, no per-word handshake
  always @(posedge clk_i) begin
    if (reset_n_i && bus_i.beat_valid) begin
      addr_q.push_back(bus_i.addr);
      data_q.push_back(bus_i.data);
      ctl_q.push_back({bus_i.rw, bus_i.xfer_size, bus_i.low_addr, bus_i.far_mem});
    end
    if (reset_n_i && bus_i.burst_start) bursts++;
    if (reset_n_i && bus_i.bus_req && !req_reg) tenures++;
  end
endmodule
`default_nettype wire
